// ===== core/fvl_pkg.sv
/*
 * fvl_pkg: constants, state enum and carrier structs for the fast
 * voltage-loop filter selection block.
 * assumes: included before every other file of the block.
 */
package fvl_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] FVL_ADDR_GAIN  = 16'hfe22;
    localparam logic [15:0] FVL_ADDR_ZERO  = 16'hfe23;
    localparam logic [15:0] FVL_ADDR_CTRL  = 16'hfe24;
    localparam logic [15:0] FVL_ADDR_THSET = 16'hfe25;
    localparam logic [15:0] FVL_ADDR_THRD  = 16'hfe26;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] FVL_RST_GAIN  = 8'h00;
    localparam logic [7:0] FVL_RST_ZERO  = 8'h00;
    localparam logic [7:0] FVL_RST_CTRL  = 8'h00;
    localparam logic [7:0] FVL_RST_THSET = 8'h00;
    localparam int FVL_BIT_LINE_TR  = 7;
    localparam int FVL_BAND_HI      = 6;
    localparam int FVL_BAND_LO      = 5;
    localparam int FVL_DLY_HI       = 4;
    localparam int FVL_DLY_LO       = 2;
    localparam int FVL_BIT_SOFT     = 1;
    localparam int FVL_BIT_DELAYED  = 0;
    localparam int FVL_BIT_AUTO     = 7;

    // error is a signed fraction of full scale, 1.0 = 2**FVL_ERR_FRAC
    localparam int FVL_ERR_W    = 16;
    localparam int FVL_ERR_FRAC = 12;
    // 3% of full scale in error units (0.03*4096 = 122.88, rounded)
    localparam logic [15:0] FVL_PLUS3_PCT = 16'h007b;

    // two flip-flop reset release
    localparam logic [1:0] FVL_RST_SYNC_INIT = 2'h0;

    typedef enum logic [1:0] {
        FVL_ST_NORMAL = 2'b00,
        FVL_ST_FAST   = 2'b01,
        FVL_ST_HOLD   = 2'b10
    } fvl_state_t;

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] zero;
        logic [7:0] ctrl;
        logic [7:0] thset;
    } fvl_regs_t;

    typedef struct packed {
        logic        fast_sel;
        logic [7:0]  coef_gain;
        logic [7:0]  coef_zero;
    } fvl_coef_t;

endpackage : fvl_pkg

// ===== core/fvl_line_det.sv
/*
 * fvl_line_det: compares the input voltage with a manual or derived
 * threshold, flags threshold crossings and half line cycles, and keeps a
 * running average of the rectified input as the automatic threshold.
 * assumes: vin is an unsigned rectified sample, new value per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module fvl_line_det import fvl_pkg::*; #(
    parameter int VIN_W  = 7,
    parameter int AVG_SH = 6
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [VIN_W-1:0] vin,
    input  wire logic             auto_en,
    input  wire logic [VIN_W-1:0] man_thr,
    output logic                  half_cycle,
    output logic                  above,
    output logic [VIN_W-1:0]      auto_thr
);

    typedef struct packed {
        logic                    primed;
        logic                    above;
        logic                    half_cycle;
        logic [VIN_W+AVG_SH-1:0] acc;
    } fvl_det_t;

    fvl_det_t s_q;
    fvl_det_t s_d;
    logic [VIN_W-1:0] thr;

    // -----------------------------------------------------------------
    // threshold pick, compare, average
    // -----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        thr = auto_en ? s_q.acc[VIN_W+AVG_SH-1:AVG_SH] : man_thr; // R8 R9
        s_d.above = (vin > thr);                                   // R7
        // no crossing on the first compare after reset
        s_d.primed = 1'b1;
        s_d.half_cycle = s_q.primed && (s_d.above != s_q.above);   // R7
        s_d.acc = s_q.acc - (s_q.acc >> AVG_SH)
                + {{AVG_SH{1'b0}}, vin};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign half_cycle = s_q.half_cycle;
    assign above      = s_q.above;
    assign auto_thr   = s_q.acc[VIN_W+AVG_SH-1:AVG_SH]; // R11

endmodule : fvl_line_det
`default_nettype wire

// ===== core/fvl_top.sv
/*
 * fvl_top: selection between normal and fast voltage-loop filters,
 * fast-loop coefficient registers and line threshold configuration.
 * assumes: register port is a simple synchronous strobe interface fed
 * by the management bus decoder; all inputs but nrst synchronous to mclk.
 * note: the overshoot machine keeps running under soft start, so the
 * filter may stay fast for a moment once soft start ends.
 */
// Overview of operation
// R1 - An 8-bit read/write register holds the fast filter zero.
// R2 - With bit 7 set, overshoot beyond band plus 3% goes fast at once.
// R3 - Bits 6:5 pick a band of 1.5625, 3.125, 6.25 or 12.5 percent.
// R4 - Back in band, wait bits 4:2 half line cycles before going normal.
// R5 - During soft start bit 1 picks fast filter when set, else normal.
// R6 - With bit 0 set, leaving the band engages fast with return delay.
// R7 - Input voltage compared with a threshold gives period and crossings.
// R8 - Threshold register bit 7 set selects the derived threshold.
// R9 - Bits 6:0 are the threshold while automatic mode is off.
// R10 - A separate 8-bit read/write register holds the fast filter gain.
// R11 - The derived threshold reads back in a read-only 7-bit field.
// R12 - With no trigger active and no delay running, normal coefs apply; the code stays fast while the error is still outside the band.
`timescale 1ns/1ps
`default_nettype none
module fvl_top import fvl_pkg::*; #(
    parameter int ERR_W = FVL_ERR_W,
    parameter int VIN_W = 7
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [15:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    output logic                  reg_ack,
    input  wire logic signed [ERR_W-1:0] vout_err,
    input  wire logic             soft_start,
    input  wire logic [7:0]       norm_gain,
    input  wire logic [7:0]       norm_zero,
    input  wire logic [VIN_W-1:0] vin,
    output logic                  fast_active,
    output logic      [7:0]       loop_gain,
    output logic      [7:0]       loop_zero,
    output logic                  vin_above,
    output logic                  half_cycle
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        fvl_regs_t  regs;
        fvl_state_t st;
        logic [2:0] dly;
        logic [7:0] rdata;
        logic       ack;
        fvl_coef_t  coef;
        logic       above;
        logic       half;
    } fvl_top_t;

    fvl_top_t   s_q;
    fvl_top_t   s_d;
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic       det_half;
    logic       det_above;
    logic [VIN_W-1:0] auto_thr;
    // error size and band compare, combinational
    logic [ERR_W-1:0] mag;
    logic [ERR_W-1:0] band;
    logic       out_band;
    logic       over3;
    logic       go_fast;

    // band limit in error units for a two-bit code
    // one shift table keeps both band compares in step
    function automatic logic [ERR_W-1:0] band_lim(input logic [1:0] c);
        logic [ERR_W-1:0] one;
        one = ERR_W'(1) << FVL_ERR_FRAC;
        band_lim = (one >> 6) << c;  // 1/64 = 1.5625%, doubling per step
    endfunction : band_lim

    // -----------------------------------------------------------------
    // reset release through two flip-flops
    // -----------------------------------------------------------------
    // release is delayed, assertion is immediate
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= FVL_RST_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // -----------------------------------------------------------------
    // line threshold compare
    // -----------------------------------------------------------------
    // threshold pick and crossing detector
    fvl_line_det #(
        .VIN_W  (VIN_W),
        .AVG_SH (6)
    ) u_det (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .vin        (vin),
        .auto_en    (s_q.regs.thset[FVL_BIT_AUTO]),
        .man_thr    (s_q.regs.thset[VIN_W-1:0]),
        .half_cycle (det_half),
        .above      (det_above),
        .auto_thr   (auto_thr)
    );

    // -----------------------------------------------------------------
    // overshoot classification
    // -----------------------------------------------------------------
    always_comb begin
        mag  = vout_err[ERR_W-1] ? ERR_W'(-vout_err) : ERR_W'(vout_err);
        band = band_lim(s_q.regs.ctrl[FVL_BAND_HI:FVL_BAND_LO]);    // R3
        out_band = (mag > band);                                     // R3
        over3 = (mag > ERR_W'(band + ERR_W'(FVL_PLUS3_PCT)));       // R2
        go_fast = (s_q.regs.ctrl[FVL_BIT_LINE_TR] && over3)          // R2
               || (s_q.regs.ctrl[FVL_BIT_DELAYED] && out_band);      // R6
    end

    // -----------------------------------------------------------------
    // registers, selection state machine, outputs
    // -----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = reg_wr | reg_rd;
        // writes; the readback address takes none
        if (reg_wr) begin
            case (reg_addr)
                FVL_ADDR_GAIN:  s_d.regs.gain  = reg_wdata;   // R10
                FVL_ADDR_ZERO:  s_d.regs.zero  = reg_wdata;   // R1
                FVL_ADDR_CTRL:  s_d.regs.ctrl  = reg_wdata;
                FVL_ADDR_THSET: s_d.regs.thset = reg_wdata;   // R8 R9
                default: ;
            endcase
        end
        // reads; unmapped addresses give zero
        if (reg_rd) begin
            case (reg_addr)
                FVL_ADDR_GAIN:  s_d.rdata = s_q.regs.gain;
                FVL_ADDR_ZERO:  s_d.rdata = s_q.regs.zero;
                FVL_ADDR_CTRL:  s_d.rdata = s_q.regs.ctrl;
                FVL_ADDR_THSET: s_d.rdata = s_q.regs.thset;
                FVL_ADDR_THRD:  s_d.rdata = {1'b0, auto_thr}; // R11
                default:        s_d.rdata = 8'h00;
            endcase
        end

        // filter selection machine: fast on a trigger, back after
        // the delay counted in half line cycles
        case (s_q.st)
            FVL_ST_NORMAL: begin
                if (go_fast) begin
                    s_d.st = FVL_ST_FAST;
                end
            end
            FVL_ST_FAST: begin
                if (!go_fast && !out_band) begin
                    s_d.dly = s_q.regs.ctrl[FVL_DLY_HI:FVL_DLY_LO]; // R4
                    s_d.st = (s_d.dly == 3'h0) ? FVL_ST_NORMAL
                                               : FVL_ST_HOLD;       // R4
                end
            end
            FVL_ST_HOLD: begin
                // leaving the band again cancels the countdown
                if (go_fast || out_band) begin
                    s_d.st = FVL_ST_FAST;
                end else if (det_half) begin
                    s_d.dly = s_q.dly - 3'h1;                        // R4
                    if (s_q.dly == 3'h1) begin
                        s_d.st = FVL_ST_NORMAL;                      // R12
                    end
                end
            end
            default: s_d.st = FVL_ST_NORMAL;
        endcase

        // soft start overrides the overshoot machine
        if (soft_start) begin
            s_d.coef.fast_sel = s_q.regs.ctrl[FVL_BIT_SOFT];         // R5
        end else begin
            s_d.coef.fast_sel = (s_d.st != FVL_ST_NORMAL);           // R12
        end
        // coefficient mux follows the next selection, no extra lag
        s_d.coef.coef_gain = s_d.coef.fast_sel ? s_d.regs.gain
                                               : norm_gain;          // R12
        s_d.coef.coef_zero = s_d.coef.fast_sel ? s_d.regs.zero
                                               : norm_zero;          // R1
        s_d.above = det_above;
        s_d.half  = det_half;
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    // held in reset until the synchronised release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{regs: '{gain: FVL_RST_GAIN, zero: FVL_RST_ZERO,
                             ctrl: FVL_RST_CTRL, thset: FVL_RST_THSET},
                     st: FVL_ST_NORMAL, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs, each straight from the state register
    // -----------------------------------------------------------------
    assign reg_rdata   = s_q.rdata;
    assign reg_ack     = s_q.ack;
    assign fast_active = s_q.coef.fast_sel;
    assign loop_gain   = s_q.coef.coef_gain;
    assign loop_zero   = s_q.coef.coef_zero;
    assign vin_above   = s_q.above;
    assign half_cycle  = s_q.half;

endmodule : fvl_top
`default_nettype wire

// ===== testbench/fvl_top_sva.sv
/* fvl_top_sva: port checks of fvl_top.
 * assumes: bound below; mirrors ctrl and zero. */
`timescale 1ns/1ps
`default_nettype none
module fvl_top_sva import fvl_pkg::*; #(
    parameter int ERR_W = FVL_ERR_W
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_ack,
    input wire logic signed [ERR_W-1:0] vout_err,
    input wire logic              soft_start,
    input wire logic [7:0]        norm_gain,
    input wire logic [7:0]        norm_zero,
    input wire logic              fast_active,
    input wire logic [7:0]        loop_gain,
    input wire logic [7:0]        loop_zero
);
    // ----
    // register mirror
    // ----
    logic [7:0]       ctrl_q;
    logic [7:0]       zero_q;
    logic [2:0]       up_q;
    logic             live;
    logic [ERR_W-1:0] mag;
    logic [ERR_W-1:0] band;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 8'h00;
            zero_q <= 8'h00;
            up_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == FVL_ADDR_CTRL) ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == FVL_ADDR_ZERO) zero_q <= reg_wdata;
            if (up_q != 3'h7) up_q <= up_q + 3'h1;
        end
    end
    // error size and band from the mirror
    assign live = (up_q == 3'h7);
    assign mag = vout_err[ERR_W-1] ? ERR_W'(-vout_err) : ERR_W'(vout_err);
    assign band = ERR_W'(16'h0040) << ctrl_q[FVL_BAND_HI:FVL_BAND_LO];
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_ack; live |-> reg_ack == $past(reg_wr || reg_rd); endproperty
    a_ack: assert property (p_ack) else $error("ack wrong");
    property p_rd_ctrl;
        $past(reg_rd && !reg_wr && reg_addr == FVL_ADDR_CTRL)
        |-> reg_rdata == $past(ctrl_q);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl read");
    property p_rd_th;
        $past(reg_rd && reg_addr == FVL_ADDR_THRD) |-> !reg_rdata[7];
    endproperty
    a_rd_th: assert property (p_rd_th) else $error("readback bit7");
    property p_soft;
        soft_start && live |=> fast_active == $past(ctrl_q[FVL_BIT_SOFT]);
    endproperty
    a_soft: assert property (p_soft) else $error("soft start select");
    property p_dly;
        live && !soft_start && ctrl_q[FVL_BIT_DELAYED] && mag > band
        |-> ##[1:2] fast_active;
    endproperty
    a_dly: assert property (p_dly) else $error("band exit not fast");
    property p_line;
        live && !soft_start && ctrl_q[FVL_BIT_LINE_TR]
        && mag > band + ERR_W'(FVL_PLUS3_PCT) |-> ##[1:2] fast_active;
    endproperty
    a_line: assert property (p_line) else $error("overshoot not fast");
    property p_idle;
        live && !soft_start && !fast_active && !ctrl_q[FVL_BIT_LINE_TR]
        && !ctrl_q[FVL_BIT_DELAYED] |=> !fast_active;
    endproperty
    a_idle: assert property (p_idle) else $error("fast w/o trigger");
    property p_ret;
        live && !soft_start && fast_active && mag <= band
        && ctrl_q[FVL_DLY_HI:FVL_DLY_LO] == 3'h0 |-> ##[1:2] !fast_active;
    endproperty
    a_ret: assert property (p_ret) else $error("no return");
    property p_norm;
        live && !fast_active
        |-> loop_gain == $past(norm_gain) && loop_zero == $past(norm_zero);
    endproperty
    a_norm: assert property (p_norm) else $error("normal coefs");
    property p_fast; live && fast_active |-> loop_zero == zero_q;
    endproperty
    a_fast: assert property (p_fast) else $error("fast zero");
endmodule : fvl_top_sva
bind fvl_top fvl_top_sva #(.ERR_W(ERR_W)) fvl_top_sva_i (
    .mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .vout_err(vout_err), .soft_start(soft_start),
    .norm_gain(norm_gain), .norm_zero(norm_zero),
    .fast_active(fast_active), .loop_gain(loop_gain), .loop_zero(loop_zero));
`default_nettype wire

// ===== testbench/testbench.sv
/* testbench: self-checking bench for fvl_top.
 * assumes: checker bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module testbench import fvl_pkg::*;;
    logic mclk, nrst, reg_wr, reg_rd, soft_start, reg_ack;
    logic fast_active, vin_above, half_cycle;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, norm_gain, norm_zero;
    logic [7:0] loop_gain, loop_zero, g, z, t;
    logic signed [15:0] vout_err;
    logic [6:0] vin;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int miscompares, total_checks, hc, b;
    fvl_top fvl_top_i (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .vout_err(vout_err),
        .soft_start(soft_start), .norm_gain(norm_gain),
        .norm_zero(norm_zero), .vin(vin), .fast_active(fast_active),
        .loop_gain(loop_gain), .loop_zero(loop_zero),
        .vin_above(vin_above), .half_cycle(half_cycle));
    // ----
    // tasks
    // ----
    always #10 mclk = ~mclk;
    task automatic test_done;
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    // one access; result noted for the monitor
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [8:0] x);
        @(negedge mclk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        exp_q.push_back(x);
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    task automatic try_err(input int v, input logic f);
        @(negedge mclk);
        vout_err = 16'(v);
        cyc(3);
        chk({7'h0, fast_active}, {7'h0, f});
    endtask : try_err
    task automatic half(input int n);
        repeat (n) begin
            @(negedge mclk);
            vin = (vin == 7'h70) ? 7'h10 : 7'h70;
            cyc(16);
        end
    endtask : half
    // ----
    // monitor, watchdog and sequence
    // ----
    always @(negedge mclk) begin
        if (half_cycle === 1'b1) hc++;
        if (reg_ack === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
            if (e[8]) chk(reg_rdata, e[7:0]);
        end
    end
    initial begin
        #200_000;
        miscompares++;
        test_done();
    end
    initial begin
        {mclk, nrst, reg_wr, reg_rd, soft_start} = 5'h00;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        vout_err = 16'sh0000;
        vin = 7'h10;
        void'($urandom(32'hccd2_0ec3));
        norm_gain = 8'($urandom);
        norm_zero = 8'($urandom);
        cyc(8);
        nrst = 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) acc(0, FVL_ADDR_GAIN + 16'(i), 8'h00,
            {1'b1, FVL_RST_GAIN});
        for (int i = 0; i < 4; i++) begin
            t = 8'($urandom);
            acc(1, FVL_ADDR_GAIN + 16'(i), t, 9'h000);
            acc(0, FVL_ADDR_GAIN + 16'(i), 8'h00, {1'b1, t});
        end
        acc(1, 16'hfe27, 8'hff, 9'h000);
        acc(0, 16'hfe27, 8'h00, 9'h100);
        acc(1, FVL_ADDR_THRD, 8'hff, 9'h000);
        g = 8'($urandom);
        z = 8'($urandom);
        acc(1, FVL_ADDR_GAIN, g, 9'h000);
        acc(1, FVL_ADDR_ZERO, z, 9'h000);
        acc(1, FVL_ADDR_THSET, 8'h40, 9'h000);
        acc(1, FVL_ADDR_CTRL, 8'h00, 9'h000);
        try_err(4000, 0);
        chk(loop_gain, norm_gain);
        for (int c = 0; c < 4; c++) begin
            b = 64 << c;
            acc(1, FVL_ADDR_CTRL, {1'b0, 2'(c), 5'h01}, 9'h000);
            try_err(b, 0);
            try_err(-b - 1, 1);
            chk(loop_gain, g);
            chk(loop_zero, z);
            try_err(b, 0);
            acc(1, FVL_ADDR_CTRL, {1'b1, 2'(c), 5'h00}, 9'h000);
            try_err(b + 123, 0);
            try_err(b + 124, 1);
            try_err(0, 0);
        end
        acc(1, FVL_ADDR_CTRL, 8'h0d, 9'h000);
        try_err(100, 1);
        try_err(0, 1);
        hc = 0;
        half(2);
        chk({7'h0, fast_active}, 8'h01);
        half(2);
        chk({7'h0, fast_active}, 8'h00);
        chk(8'(hc), 8'h04);
        t = 8'($urandom_range(126, 1));
        acc(1, FVL_ADDR_THSET, t, 9'h000);
        vin = 7'(t + 8'h01);
        cyc(4);
        chk({7'h0, vin_above}, 8'h01);
        vin = 7'(t);
        cyc(4);
        chk({7'h0, vin_above}, 8'h00);
        acc(1, FVL_ADDR_THSET, 8'h80, 9'h000);
        vin = 7'h60;
        cyc(1500);
        acc(0, FVL_ADDR_THRD, 8'h00, {1'b1, 8'h60});
        vin = 7'h05;
        cyc(4);
        chk({7'h0, vin_above}, 8'h00);
        acc(1, FVL_ADDR_CTRL, 8'h02, 9'h000);
        soft_start = 1'b1;
        try_err(0, 1);
        acc(1, FVL_ADDR_CTRL, 8'h01, 9'h000);
        try_err(4000, 0);
        soft_start = 1'b0;
        try_err(4000, 1);
        try_err(0, 0);
        cyc(4);
        test_done();
    end
endmodule : testbench
`default_nettype wire
